// [logic/osr_pkg.sv]
/*
 osr_pkg: constants for the option word, reset init and watchdog arming.
 Assumes one core clock domain at 200 MHz.
*/
`default_nettype none
package osr_pkg;
   localparam logic [15:0] OPT_ADDR       = 16'h1fff;
   localparam logic [15:0] OPT_ALIAS      = 16'hffff;
   localparam logic [7:0]  OPT_FACTORY    = 8'h00;
   localparam logic [7:0]  OPT_RSVD_MASK  = 8'hd8;
   localparam int          BIT_SECURE     = 5;
   localparam int          BIT_WD_OFF     = 2;
   localparam int          BIT_STOP_OFF   = 1;
   localparam int          BIT_FLASH_BOOT = 0;
   localparam logic [7:0]  ERASED_READ    = 8'hff;
   localparam logic [7:0]  ZERO8          = 8'h00;
   localparam logic [14:0] PC_RESET       = 15'h0000;
   localparam logic [7:0]  SP_RESET       = 8'h6f;
   localparam logic [7:0]  IDLE_CTL_RESET = 8'h40;
   localparam logic [7:0]  TRIM_RESET     = 8'h40;
   localparam logic [7:0]  TX_EMPTY_SET   = 8'h02;
   localparam logic [7:0]  PROG_TIM_10MHZ = 8'h31;
   localparam logic [1:0]  WD_WIN_MAX     = 2'h3;
   localparam logic [5:0]  CM_RECOVER_MIN = 6'h10;
   localparam logic [5:0]  CM_RECOVER_MAX = 6'h20;
   typedef enum logic [1:0] {
      OSR_RESET = 2'b00,
      OSR_FETCH = 2'b01,
      OSR_RUN   = 2'b11
   } osr_state_t;
endpackage
`default_nettype wire

// [logic/osr_top.sv]
/*
 osr_top: option word holder, flash access guard and reset initialiser.
 Assumes flash array and programmer strobes on the core clock; reset_n
 pin and brownout come from outside and are synchronised here.
*/
`default_nettype none
module osr_top
   import osr_pkg::*;
(
   // clock and reset
   input  wire logic        clock,
   input  wire logic        rst,
   // reset sources
   input  wire logic        reset_n_pin,
   input  wire logic        brownout,
   input  wire logic        power_on,
   // programming port
   input  wire logic        ext_prog_mode,
   input  wire logic        isp_mode,
   input  wire logic        user_isp,
   input  wire logic        ext_rd,
   input  wire logic        ext_wr,
   input  wire logic        page_erase,
   input  wire logic        mass_erase,
   input  wire logic [15:0] ext_addr,
   input  wire logic [7:0]  ext_wdata,
   output logic [7:0]       ext_rdata,
   output logic             wr_allow,
   output logic             page_erase_allow,
   output logic             mass_erase_allow,
   // flash array side
   input  wire logic [7:0]  flash_rdata,
   input  wire logic [7:0]  flash_opt_word,
   output logic             flash_wr,
   output logic             flash_page_erase,
   output logic             flash_mass_erase,
   // configuration outputs
   output logic             core_reset,
   output logic             secure,
   output logic             watchdog_en,
   output logic             stop_allowed,
   output logic             boot_from_flash,
   // reset init values
   output logic [14:0]      program_counter,
   output logic [7:0]       stack_pointer,
   output logic [7:0]       processor_status_word,
   output logic [7:0]       main_control_reg,
   output logic [7:0]       interrupt_control_reg,
   output logic [7:0]       timer_two_control,
   output logic [7:0]       timer_three_control,
   output logic [7:0]       fast_timer_control,
   output logic [7:0]       idle_timer_control,
   output logic [7:0]       wake_enable_reg,
   output logic [7:0]       wake_edge_reg,
   output logic [7:0]       data_segment_reg,
   output logic [7:0]       serial_prescaler,
   output logic [7:0]       serial_control_a,
   output logic [7:0]       serial_receive_ctl,
   output logic [7:0]       serial_irq_ctl,
   output logic [7:0]       converter_enable_reg,
   output logic [7:0]       amp_trim_neg,
   output logic [7:0]       amp_trim_pos,
   output logic [7:0]       amp_gain_reg,
   output logic [7:0]       prog_addr_low,
   output logic [7:0]       prog_addr_high,
   output logic [7:0]       prog_timing_reg,
   output logic             keep_warm_state,
   // watchdog and clock monitor
   input  wire logic        idle_timer_tick,
   input  wire logic        clock_ok,
   output logic [1:0]       wd_window,
   output logic             wd_armed,
   output logic             cm_armed,
   // port pins
   output logic             port_b_oe,
   output logic             port_l_oe,
   output logic             port_g_oe,
   output logic             port_g_pin_zero_pullup,
   output logic             port_g_pin_two_pullup,
   output logic             watchdog_out_pin,
   output logic             watchdog_out_pin_oe,
   output logic             watchdog_out_pin_pullup
);

   // reset source synchronisers
   logic       rpin_s1, rpin_s2, bo_s1, bo_s2, po_s1, po_s2;
   logic       ck_s1, ck_s2;
   logic       cold_seen;
   osr_state_t state;
   osr_state_t next_state;
   logic [7:0] opt;
   logic [5:0] cm_count;
   logic       cm_fault;

   always_ff @(posedge clock) begin
      rpin_s1 <= reset_n_pin;
      rpin_s2 <= rpin_s1;
      bo_s1   <= brownout;
      bo_s2   <= bo_s1;
      po_s1   <= power_on;
      po_s2   <= po_s1;
      ck_s1   <= clock_ok;
      ck_s2   <= ck_s1;
   end

   // rst, the reset pin or brownout held one cycle starts a full init
   wire reset_req = rst | ~rpin_s2 | bo_s2;

   always_comb begin
      case (state)
         OSR_RESET: next_state = OSR_FETCH;
         OSR_FETCH: next_state = OSR_RUN;
         OSR_RUN:   next_state = OSR_RUN;
         default:   next_state = OSR_RESET;
      endcase
   end

   always_ff @(posedge clock) begin
      if (reset_req) state <= OSR_RESET;
      else           state <= next_state;
   end

   wire in_reset = (state != OSR_RUN);
   assign core_reset = in_reset;

   // latch loaded from the array while the core is held
   // mass erase beats fetch: the array reads zeros right after it
   always_ff @(posedge clock) begin
      if (rst)                       opt <= OPT_FACTORY;
      else if (flash_mass_erase)     opt <= OPT_FACTORY;
      else if (state == OSR_FETCH)   opt <= flash_opt_word;
   end

   assign secure          = opt[BIT_SECURE];
   assign watchdog_en     = ~opt[BIT_WD_OFF];
   assign stop_allowed    = ~opt[BIT_STOP_OFF];
   assign boot_from_flash = opt[BIT_FLASH_BOOT];

   // access guard
   wire prog_mode  = ext_prog_mode | isp_mode;
   wire opt_hit    = (ext_addr == OPT_ADDR);
   wire alias_hit  = (ext_addr == OPT_ALIAS);
   // reserved bits are the programmer's duty; we store what arrives
   wire wr_opt     = opt_hit & prog_mode;
   assign wr_allow = ext_wr & (user_isp | (prog_mode & ~secure)) &
                     (~opt_hit | wr_opt);
   assign page_erase_allow = page_erase & (user_isp | ~secure);
   assign mass_erase_allow = mass_erase & ~user_isp;
   assign flash_wr         = wr_allow;
   assign flash_page_erase = page_erase_allow;
   assign flash_mass_erase = mass_erase_allow;

   wire [7:0] rd_sel = alias_hit ? opt :
                       (opt_hit ? opt :
                       ((secure & ~user_isp) ? ERASED_READ : flash_rdata));

   always_ff @(posedge clock) begin
      if (rst)         ext_rdata <= ZERO8;
      else if (ext_rd) ext_rdata <= rd_sel;
   end

   // cold flag: power_on pulses high once after supply rise
   always_ff @(posedge clock) begin
      if (rst)        cold_seen <= 1'b1;
      else if (po_s2) cold_seen <= 1'b1;
      else if (!in_reset) cold_seen <= 1'b0;
   end
   assign keep_warm_state = ~cold_seen;

   // register initialisation; core owns them after release
   always_ff @(posedge clock) begin
      if (in_reset) begin
         program_counter       <= PC_RESET;
         processor_status_word <= ZERO8;
         main_control_reg      <= ZERO8;
         interrupt_control_reg <= ZERO8;
         timer_two_control     <= ZERO8;
         timer_three_control   <= ZERO8;
         fast_timer_control    <= ZERO8;
         wake_enable_reg       <= ZERO8;
         wake_edge_reg         <= ZERO8;
         data_segment_reg      <= ZERO8;
         idle_timer_control    <= IDLE_CTL_RESET;
         stack_pointer         <= SP_RESET;
         serial_prescaler      <= ZERO8;
         serial_control_a      <= TX_EMPTY_SET;
         serial_receive_ctl    <= ZERO8;
         serial_irq_ctl        <= ZERO8;
         amp_trim_neg          <= TRIM_RESET;
         amp_trim_pos          <= TRIM_RESET;
         amp_gain_reg          <= ZERO8;
         converter_enable_reg  <= ZERO8;
         prog_addr_low         <= ZERO8;
         prog_addr_high        <= ZERO8;
         prog_timing_reg       <= PROG_TIM_10MHZ;
      end
   end

   // watchdog arming, inhibited while held
   always_ff @(posedge clock) begin
      if (in_reset) begin
         wd_window <= WD_WIN_MAX;
         wd_armed  <= 1'b0;
         cm_armed  <= 1'b0;
      end else begin
         wd_armed  <= watchdog_en;
         cm_armed  <= watchdog_en;
      end
   end

   // recovery counts idle ticks after clock good; fault clears on the 17th tick
   always_ff @(posedge clock) begin
      if (in_reset) begin
         cm_count <= ZERO8[5:0];
         cm_fault <= 1'b0;
      end else if (cm_armed && !ck_s2) begin
         cm_fault <= 1'b1;
         cm_count <= ZERO8[5:0];
      end else if (cm_fault && idle_timer_tick) begin
         if (cm_count == CM_RECOVER_MIN) cm_fault <= 1'b0;
         else cm_count <= cm_count + 6'h01;
      end
   end

   // port state
   assign port_b_oe = ~in_reset & 1'b0;
   assign port_l_oe = 1'b0;
   assign port_g_oe = 1'b0;
   assign port_g_pin_zero_pullup  = in_reset;
   assign port_g_pin_two_pullup   = in_reset;
   assign watchdog_out_pin        = ~cm_fault;
   assign watchdog_out_pin_oe     = watchdog_en & cm_fault;
   assign watchdog_out_pin_pullup = watchdog_en;

   // checks
   secure_read_a: assert property (@(posedge clock) disable iff (rst)
      (ext_rd && secure && !user_isp && !opt_hit && !alias_hit)
      |=> ext_rdata == ERASED_READ)
      else $error("secured read not all ones");
   alias_read_a: assert property (@(posedge clock) disable iff (rst)
      (ext_rd && alias_hit) |=> ext_rdata == $past(opt))
      else $error("alias read wrong");
   secure_write_a: assert property (@(posedge clock) disable iff (rst)
      (secure && !user_isp) |-> !flash_wr && !flash_page_erase)
      else $error("secured write passed");
   opt_write_a: assert property (@(posedge clock) disable iff (rst)
      (flash_wr && opt_hit) |-> (ext_prog_mode || isp_mode))
      else $error("option write outside program mode");
   opt_fetch_a: assert property (@(posedge clock) disable iff (rst)
      (state == OSR_FETCH) |=> opt == ($past(flash_mass_erase) ?
         OPT_FACTORY : $past(flash_opt_word)))
      else $error("option fetch missed");
   sp_init_a: assert property (@(posedge clock) disable iff (rst)
      (in_reset ##1 !in_reset) |-> stack_pointer == SP_RESET)
      else $error("stack pointer init wrong");
   wd_hold_a: assert property (@(posedge clock) disable iff (rst)
      in_reset |=> !wd_armed && wd_window == WD_WIN_MAX)
      else $error("watchdog armed in reset");
   cm_pin_a: assert property (@(posedge clock) disable iff (rst)
      (cm_armed && !ck_s2 && !in_reset) |=> !watchdog_out_pin)
      else $error("clock fault pin not low");
   erase_clear_a: assert property (@(posedge clock) disable iff (rst)
      (flash_mass_erase && state == OSR_RUN) |=> !secure)
      else $error("mass erase kept secure");
   reset_req_a: assert property (@(posedge clock) disable iff (rst)
      (!rpin_s2) |=> core_reset [*2])
      else $error("reset pin ignored");
   init_core_a: assert property (@(posedge clock) disable iff (rst)
      (in_reset ##1 !in_reset) |-> program_counter == PC_RESET &&
      processor_status_word == ZERO8 && main_control_reg == ZERO8 &&
      interrupt_control_reg == ZERO8)
      else $error("core registers not cleared");
   init_timer_a: assert property (@(posedge clock) disable iff (rst)
      (in_reset ##1 !in_reset) |-> timer_two_control == ZERO8 &&
      timer_three_control == ZERO8 && fast_timer_control == ZERO8 &&
      wake_enable_reg == ZERO8 && wake_edge_reg == ZERO8 &&
      data_segment_reg == ZERO8)
      else $error("timer or wake registers not cleared");
   idle_ctl_a: assert property (@(posedge clock) disable iff (rst)
      (in_reset ##1 !in_reset) |-> idle_timer_control == IDLE_CTL_RESET)
      else $error("idle control init wrong");
   serial_init_a: assert property (@(posedge clock) disable iff (rst)
      (in_reset ##1 !in_reset) |-> serial_prescaler == ZERO8 &&
      serial_control_a == TX_EMPTY_SET && serial_receive_ctl == ZERO8 &&
      serial_irq_ctl == ZERO8)
      else $error("serial init wrong");
   analog_init_a: assert property (@(posedge clock) disable iff (rst)
      (in_reset ##1 !in_reset) |-> amp_trim_neg == TRIM_RESET &&
      amp_trim_pos == TRIM_RESET && amp_gain_reg == ZERO8 &&
      converter_enable_reg == ZERO8 && prog_addr_low == ZERO8 &&
      prog_addr_high == ZERO8 && prog_timing_reg == PROG_TIM_10MHZ)
      else $error("analog or program timing init wrong");
   port_float_a: assert property (@(posedge clock) disable iff (rst)
      core_reset |-> !port_b_oe && !port_l_oe && !port_g_oe &&
      port_g_pin_zero_pullup && port_g_pin_two_pullup)
      else $error("port state in reset wrong");
   wd_arm_a: assert property (@(posedge clock) disable iff (rst)
      (!in_reset && watchdog_en) |=> wd_armed && cm_armed)
      else $error("watchdog not armed after reset");
   win_max_a: assert property (@(posedge clock) disable iff (rst)
      !in_reset |-> wd_window == WD_WIN_MAX)
      else $error("service window not maximum");
   wd_off_a: assert property (@(posedge clock) disable iff (rst)
      !watchdog_en |-> !watchdog_out_pin_oe && !watchdog_out_pin_pullup)
      else $error("watchdog pin driven while disabled");
   cm_drive_a: assert property (@(posedge clock) disable iff (rst)
      (cm_fault && watchdog_en) |-> !watchdog_out_pin && watchdog_out_pin_oe)
      else $error("clock fault pin not driven low");
   cm_release_a: assert property (@(posedge clock) disable iff (rst)
      (cm_fault && idle_timer_tick && ck_s2 && cm_count == CM_RECOVER_MIN)
      |=> watchdog_out_pin)
      else $error("clock fault pin not released");
   cm_span_a: assert property (@(posedge clock) disable iff (rst)
      cm_count <= CM_RECOVER_MAX)
      else $error("clock fault recovery too long");
   cold_mark_a: assert property (@(posedge clock) disable iff (rst)
      po_s2 |=> !keep_warm_state)
      else $error("power on reset seen as warm");
   plain_read_a: assert property (@(posedge clock) disable iff (rst)
      (ext_rd && !secure && !opt_hit && !alias_hit)
      |=> ext_rdata == $past(flash_rdata))
      else $error("open read wrong");
   opt_read_a: assert property (@(posedge clock) disable iff (rst)
      (ext_rd && opt_hit) |=> ext_rdata == $past(opt))
      else $error("option read wrong");
   fetch_first_a: assert property (@(posedge clock) disable iff (rst)
      $fell(core_reset) |-> $past(state) == OSR_FETCH)
      else $error("core released without option fetch");
   mass_gate_a: assert property (@(posedge clock) disable iff (rst)
      (mass_erase && user_isp) |-> !flash_mass_erase)
      else $error("mass erase passed under user isp");

endmodule
`default_nettype wire

// [testbench/osr_flash_model.sv]
/*
 osr_flash_model: flash array and programmer side behind osr_top.
 Assumes osr_top gates every strobe before it reaches this model.
*/
`default_nettype none
module osr_flash_model
   import osr_pkg::*;
(
   // clock
   input  wire logic        clock,
   // array access
   input  wire logic [15:0] ext_addr,
   input  wire logic [7:0]  ext_wdata,
   input  wire logic        flash_wr,
   input  wire logic        flash_page_erase,
   input  wire logic        flash_mass_erase,
   output logic [7:0]       flash_rdata,
   output logic [7:0]       flash_opt_word
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] opt_q = OPT_FACTORY;
   wire        opt_hit = ext_addr == OPT_ADDR;
   // plain cells hold a pattern so a leak past the guard shows up
   assign flash_rdata    = opt_hit ? opt_q : 8'h5a;
   assign flash_opt_word = opt_q;
   always @(posedge clock) begin
      if (flash_mass_erase)
         opt_q <= OPT_FACTORY;
      else if (flash_page_erase && ext_addr[15:6] == OPT_ADDR[15:6])
         opt_q <= OPT_FACTORY;
      else if (flash_wr && opt_hit)
         opt_q <= ext_wdata;
   end
endmodule
`default_nettype wire

// [testbench/tb.sv]
/*
 tb: self-checking bench for osr_top with the flash model beside it.
 Assumes osr_pkg is compiled first; inputs change on the falling edge.
*/
`default_nettype none
module tb
   import osr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 0, rst = 1, reset_n_pin = 1, brownout = 0, power_on = 1;
   logic ext_prog_mode = 0, isp_mode = 0, user_isp = 0, ext_rd = 0;
   logic ext_wr = 0, page_erase = 0, mass_erase = 0;
   logic idle_timer_tick = 0, clock_ok = 1;
   logic [15:0] ext_addr = 16'h0000;
   logic [7:0]  ext_wdata = 8'h00, ext_rdata, flash_rdata, flash_opt_word;
   logic wr_allow, page_erase_allow, mass_erase_allow, flash_wr;
   logic flash_page_erase, flash_mass_erase, core_reset, secure;
   logic watchdog_en, stop_allowed, boot_from_flash, keep_warm_state;
   logic [14:0] program_counter;
   logic [7:0]  stack_pointer, processor_status_word, main_control_reg;
   logic [7:0]  interrupt_control_reg, timer_two_control, timer_three_control;
   logic [7:0]  fast_timer_control, idle_timer_control, wake_enable_reg;
   logic [7:0]  wake_edge_reg, data_segment_reg, serial_prescaler;
   logic [7:0]  serial_control_a, serial_receive_ctl, serial_irq_ctl;
   logic [7:0]  converter_enable_reg, amp_trim_neg, amp_trim_pos;
   logic [7:0]  amp_gain_reg, prog_addr_low, prog_addr_high, prog_timing_reg;
   logic [1:0]  wd_window;
   logic wd_armed, cm_armed, port_b_oe, port_l_oe, port_g_oe;
   logic port_g_pin_zero_pullup, port_g_pin_two_pullup, watchdog_out_pin;
   logic watchdog_out_pin_oe, watchdog_out_pin_pullup;
   int   miscompares = 0, compares = 0;

   osr_top u_osr_top (.*);
   osr_flash_model u_osr_flash_model (.*);

   always #2.5 clock = ~clock;

   task automatic end_of_test;
      if (miscompares == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      compares++;
      if (seen !== want) begin
         miscompares++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
      end
   endtask

   task automatic wait_core(input logic level);
      int n;
      n = 0;
      while (core_reset !== level && n < 50) begin
         @(negedge clock);
         n++;
      end
      check(core_reset, level);
   endtask

   task automatic do_reset(input logic cold);
      @(negedge clock);
      power_on = cold;
      brownout = cold;
      reset_n_pin = cold;
      wait_core(1);
      @(negedge clock);
      check(keep_warm_state, !cold);
      check({port_b_oe, port_l_oe, port_g_oe, port_g_pin_zero_pullup,
             port_g_pin_two_pullup, wd_armed, cm_armed}, 7'b0001100);
      power_on = 0;
      brownout = 0;
      reset_n_pin = 1;
      wait_core(0);
   endtask

   task automatic rd(input logic [15:0] a, input logic [7:0] want);
      @(negedge clock);
      ext_addr = a;
      ext_rd = 1;
      @(negedge clock);
      ext_rd = 0;
      check(ext_rdata, want);
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic ok);
      @(negedge clock);
      ext_addr = a;
      ext_wdata = d;
      ext_wr = 1;
      #1 check(flash_wr, ok);
      check(wr_allow, ok);
      @(negedge clock);
      ext_wr = 0;
   endtask

   task automatic er(input logic mass, input logic ok);
      @(negedge clock);
      ext_addr = OPT_ADDR;
      page_erase = !mass;
      mass_erase = mass;
      #1 check(mass ? flash_mass_erase : flash_page_erase, ok);
      check(mass ? mass_erase_allow : page_erase_allow, ok);
      @(negedge clock);
      page_erase = 0;
      mass_erase = 0;
   endtask

   task automatic t_init;
      // arming flops follow the release by one cycle
      @(negedge clock);
      check(program_counter, PC_RESET);
      check({processor_status_word, main_control_reg, interrupt_control_reg,
             timer_two_control}, 32'h0);
      check({timer_three_control, fast_timer_control, wake_enable_reg,
             wake_edge_reg}, 32'h0);
      check({data_segment_reg, idle_timer_control, stack_pointer},
            24'h00406f);
      check({serial_prescaler, serial_control_a, serial_receive_ctl,
             serial_irq_ctl}, {ZERO8, TX_EMPTY_SET, 16'h0});
      check({amp_trim_neg, amp_trim_pos, amp_gain_reg, converter_enable_reg},
            32'h40400000);
      check({prog_addr_low, prog_addr_high, prog_timing_reg},
            {16'h0, PROG_TIM_10MHZ});
      check({secure, watchdog_en, stop_allowed, boot_from_flash},
            4'b0110);
      check({wd_window, wd_armed, cm_armed, watchdog_out_pin_pullup},
            {WD_WIN_MAX, 3'b111});
      rd(OPT_ALIAS, 8'h00);
      rd(16'h0123, 8'h5a);
   endtask

   task automatic t_secure;
      wr(OPT_ADDR, 8'h27, 0);
      ext_prog_mode = 1;
      er(0, 1);
      wr(OPT_ADDR, 8'h27, 1);
      ext_prog_mode = 0;
      do_reset(0);
      check({secure, watchdog_en, stop_allowed, boot_from_flash,
             watchdog_out_pin_pullup}, 5'b10010);
      rd(16'h0123, ERASED_READ);
      rd(OPT_ALIAS, 8'h27);
      rd(OPT_ADDR, 8'h27);
      ext_prog_mode = 1;
      wr(16'h0123, 8'h11, 0);
      wr(OPT_ADDR, 8'h00, 0);
      er(0, 0);
      user_isp = 1;
      er(1, 0);
      user_isp = 0;
      er(1, 1);
      ext_prog_mode = 0;
      check(secure, 0);
      rd(OPT_ALIAS, 8'h00);
      isp_mode = 1;
      wr(OPT_ADDR, 8'h01, 1);
      isp_mode = 0;
   endtask

   task automatic tick;
      @(negedge clock);
      idle_timer_tick = 1;
      @(negedge clock);
      idle_timer_tick = 0;
   endtask

   task automatic t_clock_fault;
      check({secure, watchdog_en, stop_allowed, boot_from_flash},
            4'b0111);
      @(negedge clock);
      clock_ok = 0;
      repeat (4) @(negedge clock);
      check({watchdog_out_pin, watchdog_out_pin_oe}, 2'b01);
      clock_ok = 1;
      repeat (15) tick;
      check(watchdog_out_pin, 0);
      repeat (17) tick;
      check(watchdog_out_pin, 1);
   endtask

   initial begin
      repeat (16) @(negedge clock);
      rst = 0;
      wait_core(0);
      do_reset(1);
      t_init;
      t_secure;
      do_reset(1);
      t_clock_fault;
      end_of_test;
   end

   // the tests need well under a thousand cycles; this is ten times that
   initial begin
      #50000;
      miscompares++;
      end_of_test;
   end
endmodule
`default_nettype wire
